// File: verilog/adc_readout_pkg.sv
// constants for the serial readout and conversion sequencer
// assumes a 200 MHz system clock sampling the frame select and shift clock pins
package adc_readout_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int FRAME_CYCLES = 16;                      // shift clocks per conversion
  localparam int LEAD_ZEROS = 4;
  localparam int RESULT_BITS_HI = 12;
  localparam int RESULT_BITS_LO = 10;
  localparam int CONV_DURATION_NS_MAX = 888;
  localparam int INTER_FRAME_GAP_NS = 60;
  localparam int FRAME_PULSE_NS = 10;
  localparam int DRIVE_ON_NS_MAX = 20;
  localparam int BIT_VALID_NS_MAX = 40;
  localparam int RELEASE_NS_MIN = 10;
  localparam int RELEASE_NS_MAX = 35;
  localparam int WAKE_UP_INTERVAL_NS = 1000;
  localparam int SYNC_STAGES = 2;
  // a longest time rounds down; pin latency is the synchroniser's two cycles plus one registered stage after it
  localparam int DRIVE_ON_CYC = DRIVE_ON_NS_MAX / CLK_PERIOD_NS;
  localparam int BIT_VALID_CYC = BIT_VALID_NS_MAX / CLK_PERIOD_NS;
  localparam int RELEASE_CYC_MIN = (RELEASE_NS_MIN + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC_MAX = RELEASE_NS_MAX / CLK_PERIOD_NS;
  localparam int PIN_LATENCY = SYNC_STAGES + 1;
  localparam logic [4:0] COUNT_RESET = 5'h00;
endpackage : adc_readout_pkg

// File: verilog/pin_sync.sv
// two-stage synchroniser for the pins that come from the controller
// assumes the pins are asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import adc_readout_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // raw and synchronised pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // idle level of every pin is high (select deasserted, clock parked high)
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      meta_reg <= '1;
      sync_reg <= '1;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync_out = sync_reg;
endmodule : pin_sync
`default_nettype wire

// File: verilog/adc_serial_readout.sv
// serial readout and conversion sequencer of a differential SAR converter
// assumes frame select and shift clock come from an outside controller and are
// sampled by mclk; the analog result arrives on sample_code at the frame's start
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout
  import adc_readout_pkg::*;
#(
  parameter int RESULT_BITS = RESULT_BITS_HI
)
(
  // system clock and reset
  input wire logic mclk,
  input wire logic srst,
  // controller pins
  input wire logic frame_sel_n,
  input wire logic shift_clk,
  // serial result pin, three signals
  input wire logic result_serial_in,
  output logic result_serial_out,
  output logic result_serial_oe,
  // analog side: two's complement code held by the sampler
  input wire logic [RESULT_BITS-1:0] sample_code,
  // status
  output logic conversion_busy,
  output logic result_ready
);
  typedef enum logic [1:0] {IDLE, CONVERT, DONE} state_t;

  localparam int PAD_BITS = FRAME_CYCLES - LEAD_ZEROS - RESULT_BITS;

  logic [1:0] pins_sync;
  logic sel_n_s;
  logic sck_s;
  logic sel_n_d_reg;
  logic sck_d_reg;
  logic sel_fall;
  logic sel_rise;
  logic sck_fall;
  state_t state_reg;
  logic [4:0] count_reg;
  logic [FRAME_CYCLES-1:0] shift_reg;
  logic [FRAME_CYCLES-1:0] frame_word;

  pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .mclk(mclk),
    .srst(srst),
    .pin_in({frame_sel_n, shift_clk}),
    .pin_sync_out(pins_sync)
  );

  assign sel_n_s = pins_sync[1];
  assign sck_s = pins_sync[0];

  // edge history of the synchronised pins
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sel_n_d_reg <= 1'b1;
      sck_d_reg <= 1'b1;
    end
    else
    begin
      sel_n_d_reg <= sel_n_s;
      sck_d_reg <= sck_s;
    end
  end

  assign sel_fall = sel_n_d_reg & ~sel_n_s;
  assign sel_rise = ~sel_n_d_reg & sel_n_s;
  assign sck_fall = sck_d_reg & ~sck_s;

  // leading zeros, code MSB first, then trailing zero pad; placed by index so that a
  // zero-width pad never appears as a replication
  always_comb
  begin
    frame_word = '0;
    frame_word[PAD_BITS +: RESULT_BITS] = sample_code;
  end

  // conversion sequencer: the shift clock itself steps it, no other timebase
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_reg <= IDLE;
      count_reg <= COUNT_RESET;
    end
    else if (sel_rise)
    begin
      // early release aborts the frame; the partial result is discarded
      state_reg <= IDLE;
      count_reg <= COUNT_RESET;
    end
    else
    begin
      unique case (state_reg)
        IDLE:
        begin
          if (sel_fall)
          begin
            state_reg <= CONVERT;
            count_reg <= COUNT_RESET;
          end
        end
        CONVERT:
        begin
          if (sck_fall)
          begin
            count_reg <= count_reg + 5'h01;
            if (count_reg == 5'(FRAME_CYCLES - 1))
            begin
              state_reg <= DONE;
            end
          end
        end
        DONE:
        begin
          state_reg <= DONE; // waits for select to rise
        end
        default:
        begin
          // the fourth code of the state register is never used
          state_reg <= IDLE;
          count_reg <= COUNT_RESET;
        end
      endcase
    end
  end

  // output shifter: first bit sits at select fall, next on each shift clock fall
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      shift_reg <= '0;
    end
    else if (state_reg == IDLE && sel_fall)
    begin
      shift_reg <= frame_word;
    end
    else if (state_reg == CONVERT && sck_fall)
    begin
      shift_reg <= {shift_reg[FRAME_CYCLES-2:0], 1'b0};
    end
  end

  // pin drive: data and enable registered, released after the sixteenth fall
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      result_serial_out <= 1'b0;
      result_serial_oe <= 1'b0;
    end
    else
    begin
      result_serial_out <= shift_reg[FRAME_CYCLES-1];
      result_serial_oe <= (state_reg == CONVERT) && !sel_rise;
    end
  end

  // status flags for the analog side
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      conversion_busy <= 1'b0;
      result_ready <= 1'b0;
    end
    else
    begin
      conversion_busy <= (state_reg == CONVERT);
      result_ready <= (state_reg == DONE);
    end
  end

  // the return path of the pin is not needed by this end
  logic unused_in;
  assign unused_in = result_serial_in;

  // enable rises within the drive-on bound of select falling
  sequence frame_open_s;
    state_reg == IDLE && sel_fall;
  endsequence

  // one shift clock fall inside an open frame
  sequence bit_step_s;
    state_reg == CONVERT && sck_fall && !sel_rise;
  endsequence

  chk_drive_on_time: assert property (@(posedge mclk) disable iff (srst)
    frame_open_s |-> ##[1:2] result_serial_oe)
    else $error("output not driven soon after frame select fell");

  // the shifter moves at the fall edge, the pin one cycle later
  chk_bit_update: assert property (@(posedge mclk) disable iff (srst)
    bit_step_s |->
      ##2 result_serial_out == $past(shift_reg[FRAME_CYCLES-2], 2))
    else $error("serial bit not updated after shift clock fall");

  chk_release_time: assert property (@(posedge mclk) disable iff (srst)
    (state_reg == CONVERT && sck_fall && count_reg == 5'(FRAME_CYCLES - 1) && !sel_rise)
      |-> ##2 !result_serial_oe)
    else $error("output not released after last shift clock");

  chk_sixteen_falls: assert property (@(posedge mclk) disable iff (srst)
    (state_reg == CONVERT && count_reg != 5'(FRAME_CYCLES - 1) && !sel_rise)
      |=> state_reg != DONE)
    else $error("conversion ended before sixteen shift clocks");

  chk_frame_start: assert property (@(posedge mclk) disable iff (srst)
    (state_reg == IDLE && sel_fall && !sel_rise) |=>
      state_reg == CONVERT && count_reg == COUNT_RESET)
    else $error("frame select fall did not start conversion");

  chk_lead_zeros: assert property (@(posedge mclk) disable iff (srst)
    frame_open_s |=> shift_reg[FRAME_CYCLES-1 -: LEAD_ZEROS] == '0)
    else $error("leading zeros missing from frame");

  chk_code_msb: assert property (@(posedge mclk) disable iff (srst)
    frame_open_s |=>
      shift_reg[FRAME_CYCLES-1-LEAD_ZEROS] == $past(sample_code[RESULT_BITS-1]))
    else $error("sign bit not first after leading zeros");

  chk_step_by_clock: assert property (@(posedge mclk) disable iff (srst)
    (state_reg == CONVERT && !sck_fall && !sel_rise) |=> $stable(count_reg))
    else $error("conversion stepped without a shift clock fall");
endmodule : adc_serial_readout
`default_nettype wire

// File: verification/ctl_model.sv
// controller model: frame select and shift clock, reads both result lines
// assumes a 48 ns shift clock that idles high; it can also run between frames (idle_clocks)
`timescale 1ns/1ps
`default_nettype none
module ctl_model
(
  // controller pins
  output logic frame_sel_n,
  output logic shift_clk,
  // result lines as seen on the board
  input wire logic [1:0] pin,
  input wire logic [1:0] pin_oe
);
  localparam int HALF_NS = 24; // even duty, both phases above 40 percent
  logic [15:0] word_a;
  logic [15:0] word_b;
  logic oe_seen;
  logic oe_early;
  logic oe_late;
  logic awake;
  // idle levels, then the wake-up allowance before any frame
  initial
  begin
    frame_sel_n = 1'b1;
    shift_clk = 1'b1;
    awake = 1'b0;
    #1000.5 awake = 1'b1; // same half-ns phase as the bench's stimulus
  end
  // select low, then falls; each bit read at the fall that replaces it
  task automatic run_frame(input int falls);
    wait (awake === 1'b1);
    word_a = 16'h0000;
    word_b = 16'h0000;
    oe_seen = 1'b1;
    frame_sel_n = 1'b0;
    // half-ns offset puts every shift clock edge on whole ns, never on a rising mclk edge
    #30.5;
    for (int i = 0; i < falls; i++)
    begin
      word_a = {word_a[14:0], pin[0]};
      word_b = {word_b[14:0], pin[1]};
      oe_seen = oe_seen & pin_oe[0] & pin_oe[1];
      shift_clk = 1'b0;
      #5;
      oe_early = pin_oe[0];
      #(HALF_NS - 5);
      shift_clk = 1'b1;
      #HALF_NS;
      oe_late = pin_oe[0];
    end
  endtask : run_frame
  // select high for at least the gap and longer than the pulse minimum
  task automatic end_frame;
    frame_sel_n = 1'b1;
    #60;
  endtask : end_frame
  // shift clock with no frame open
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      shift_clk = 1'b0;
      #HALF_NS;
      shift_clk = 1'b1;
      #HALF_NS;
    end
  endtask : idle_clocks
endmodule : ctl_model
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench: 12-bit and 10-bit readout driven by one controller model
// assumes the controller model file is compiled before this one
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adc_readout_pkg::*;
  typedef struct {logic [11:0] code; logic [15:0] hi; logic [15:0] lo;} row_t;
  row_t rows [6] = '{'{12'h000, 16'h0000, 16'h0000}, '{12'h001, 16'h0001, 16'h0000},
    '{12'h7ff, 16'h07ff, 16'h07fc}, '{12'h800, 16'h0800, 16'h0800},
    '{12'hfff, 16'h0fff, 16'h0ffc}, '{12'ha5c, 16'h0a5c, 16'h0a5c}};
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] code_hi = 12'h000;
  wire logic [1:0] out;
  wire logic [1:0] oe;
  wire logic [1:0] busy;
  wire logic [1:0] ready;
  logic [1:0] last_v = 2'h0;
  wire logic frame_sel_n;
  wire logic shift_clk;
  wire logic [1:0] pin;
  int fail_count = 0;
  int checked = 0;
  // a released line shows the inverse of its last driven level
  assign pin = (oe & out) | (~oe & ~last_v);
  always @(posedge mclk) last_v <= (oe & out) | (~oe & last_v);
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  adc_serial_readout DUT (.mclk(mclk), .srst(srst), .frame_sel_n(frame_sel_n),
    .shift_clk(shift_clk), .result_serial_in(pin[0]), .result_serial_out(out[0]),
    .result_serial_oe(oe[0]), .sample_code(code_hi), .conversion_busy(busy[0]),
    .result_ready(ready[0]));
  adc_serial_readout #(.RESULT_BITS(RESULT_BITS_LO)) dut_narrow (.mclk(mclk), .srst(srst),
    .frame_sel_n(frame_sel_n), .shift_clk(shift_clk), .result_serial_in(pin[1]),
    .result_serial_out(out[1]), .result_serial_oe(oe[1]), .sample_code(code_hi[11:2]),
    .conversion_busy(busy[1]), .result_ready(ready[1]));
  ctl_model ctl (.frame_sel_n(frame_sel_n), .shift_clk(shift_clk), .pin(pin), .pin_oe(oe));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // ten cycles of reset, outputs checked quiet at its end, then three to flush the syncs
  task automatic do_reset;
    @(posedge mclk);
    #1 srst = 1'b1;
    repeat (10) @(posedge mclk);
    #1 chk({8'h00, out, oe, busy, ready}, 16'h0000);
    srst = 1'b0;
    repeat (3) @(posedge mclk);
  endtask : do_reset
  // whole frame on both variants, status at the end, release after select rises
  task automatic full_frame(input logic [11:0] c, input logic [15:0] hi, input logic [15:0] lo);
    @(posedge mclk);
    #1 code_hi = c;
    ctl.run_frame(FRAME_CYCLES);
    chk(ctl.word_a, hi);
    chk(ctl.word_b, lo);
    chk({11'h000, ctl.oe_seen, ctl.oe_early, ctl.oe_late, ready[0], busy[0]}, 16'h001a);
    chk({14'h0000, ready[1], busy[1]}, 16'h0002);
    ctl.end_frame;
    chk({12'h000, ready, oe}, 16'h0000);
  endtask : full_frame
  // bounds the whole run
  initial
  begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    wrap_up;
  end
  // table first, then abort, stray clocks and a second reset
  initial
  begin
    do_reset;
    foreach (rows[i])
      full_frame(rows[i].code, rows[i].hi, rows[i].lo);
    @(posedge mclk);
    #1 ctl.run_frame(5);
    chk({14'h0000, busy[0], ready[0]}, 16'h0002);
    ctl.end_frame;
    chk({14'h0000, oe}, 16'h0000);
    full_frame(12'h3c5, 16'h03c5, 16'h03c4);
    ctl.idle_clocks(4);
    chk({12'h000, oe, busy}, 16'h0000);
    do_reset;
    full_frame(12'h5a3, 16'h05a3, 16'h05a0);
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
